/* logic/ucp_pkg.sv */
// Purpose: constants and types for the usb charging port mode controller
// Assumes: one 25 MHz clock, synchronous active-low reset, AHB-Lite register access
// Notes: decode tables for both product variants live in the top module functions
// Contract
// - data switches close only in charging or standard downstream modes
// - data switches also need enable high; dsc pin variant uses dsc instead
// - in charging downstream mode switches stay closed during and after handshake
// - data switches open when qualifier low or any dedicated charging mode
// - current limiting alone never opens the data switches
// - code 000 without dsc pin: power off, discharge on, data switches open
// - no-dsc decode: 000 off, 0x1 auto, x10 sdp, 100 bc12, 101 divider, 111 cdp
// - dsc decode: 00x auto, 01x bc12, 10x divider, 110 sdp, 111 cdp
// - auto mode starts as divider; bc12 attach discharges, runs bc12 until detach
// - discharge turns power off while draining output, then power back on
// - mode change into or out of sdp or cdp runs the discharge automatically
// - host requests discharge by dsc pin, or code 000 on the other variant
// - over-current holds constant current; only thermal limit shuts down
// - first sensor over threshold while in current limit turns power off
// - second sensor over higher threshold turns power off regardless
// - after thermal trip, re-enable once cooled; keep cycling until fault gone
// - open-drain fault asserted during over-temperature or current limit
// - current limit deglitched before fault; over-temperature reported at once
// - threshold select low picks first limit set, high picks second
// - power switch held off during undervoltage, enabled once supply is good
package ucp_pkg;
   localparam int CNT_W = 12;
   localparam int DIS_CYC_DEF = 64;
   localparam int DEG_CYC_DEF = 16;
   localparam int ADDR_W = 8;

   localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;
   localparam int CTRL_DIS_BIT = 0;
   localparam int ST_MODE_LSB = 0;
   localparam int ST_AUTO_BIT = 6;
   localparam int ST_PWR_BIT = 7;
   localparam int ST_DSW_BIT = 8;
   localparam int ST_DIS_BIT = 9;
   localparam int ST_FLT_BIT = 10;
   localparam int ST_THERM_BIT = 11;

   typedef enum logic [5:0] {
      M_OFF  = 6'h01,
      M_AUTO = 6'h02,
      M_SDP  = 6'h04,
      M_BC12 = 6'h08,
      M_DIV  = 6'h10,
      M_CDP  = 6'h20
   } ucp_mode_t;

   typedef enum logic [1:0] {
      D_IDLE = 2'h1,
      D_DIS  = 2'h2
   } ucp_dis_t;
endpackage : ucp_pkg

/* logic/ucp_top.sv */
// Purpose: charging port mode decode, data switch, power switch, discharge and fault control
// Assumes: analog comparators deliver synchronous levels; sensors carry their own hysteresis
// Notes: registers over AHB-Lite, zero wait states, always OKAY
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module ucp_top import ucp_pkg::*; #(
   parameter bit HAS_DSC = 1'b0,                   // variant with dedicated discharge pin
   parameter int DIS_CYC = DIS_CYC_DEF,            // discharge interval in cycles
   parameter int DEG_CYC = DEG_CYC_DEF             // current-limit deglitch in cycles
) (
   input wire logic clk_sys_i,                     // 25 MHz system clock
   input wire logic nrst_i,                        // synchronous reset, active low
   input wire logic mode_sel_a_i,                  // control input 1
   input wire logic mode_sel_b_i,                  // control input 2
   input wire logic mode_sel_c_i,                  // control input 3
   input wire logic enable_i,                      // data switch enable, no-dsc variant
   input wire logic discharge_request_in_i,        // dsc pin, low requests discharge
   input wire logic limit_threshold_select_i,      // current-limit set select
   input wire logic current_limit_i,               // switch is regulating current
   input wire logic temp_warn_i,                   // first sensor over its threshold
   input wire logic temp_crit_i,                   // second sensor over its threshold
   input wire logic uvlo_i,                        // input supply below turn-on level
   input wire logic bc12_attach_i,                 // bc1.2 device seen in auto mode
   input wire logic hsel_i,                        // ahb select
   input wire logic [31:0] haddr_i,                // ahb address
   input wire logic [1:0] htrans_i,                // ahb transfer type
   input wire logic hwrite_i,                      // ahb write
   input wire logic [2:0] hsize_i,                 // ahb size, word only
   input wire logic [31:0] hwdata_i,               // ahb write data
   input wire logic hready_i,                      // ahb bus ready
   output logic [31:0] hrdata_o,                   // ahb read data
   output logic hreadyout_o,                       // ahb slave ready
   output logic hresp_o,                           // ahb response, always okay
   output logic data_switch_o,                     // data line pass switches closed
   output logic power_switch_o,                    // power switch on
   output logic discharge_o,                       // output discharge path connected
   output logic limit_set_high_o,                  // second limit set active
   output logic dcp_bc12_o,                        // bc1.2 short presented
   output logic dcp_divider_o,                     // divider levels presented
   output logic fault_n_o,                         // fault pin level, active low
   output logic fault_oe_o                         // fault pin pulled low
);
   typedef struct packed {
      ucp_mode_t mode;
      ucp_dis_t dis;
      logic [CNT_W-1:0] cnt;
      logic auto_bc12;
      logic therm1;
      logic [CNT_W-1:0] gcnt;
      logic ilim_flt;
      logic soft_dis;
      logic pwr;
      logic dsw;
      logic dis_en;
      logic lim_hi;
      logic bc12;
      logic div;
      logic flt;
      logic flt_n;
      logic a_sel;
      logic a_wr;
      logic [ADDR_W-1:0] a_addr;
      logic [31:0] hrdata;
      logic hready;
   } ucp_st_t;

   localparam ucp_st_t ST_RST = '{mode: M_OFF, dis: D_IDLE, cnt: '0, auto_bc12: 1'b0, therm1: 1'b0,
      gcnt: '0, ilim_flt: 1'b0, soft_dis: 1'b0, pwr: 1'b0, dsw: 1'b0, dis_en: 1'b0, lim_hi: 1'b0,
      bc12: 1'b0, div: 1'b0, flt: 1'b0, flt_n: 1'b1, a_sel: 1'b0, a_wr: 1'b0, a_addr: '0,
      hrdata: '0, hready: 1'b1};
   localparam logic [CNT_W-1:0] DIS_LAST = CNT_W'(DIS_CYC - 1);
   localparam logic [CNT_W-1:0] DEG_LAST = CNT_W'(DEG_CYC - 1);

   ucp_st_t st_q;
   ucp_st_t st_d;
   ucp_mode_t dec;
   logic qual;
   logic dsc_req;
   logic auto_go;
   logic mode_chg;
   logic start;
   logic th_off;
   logic wr_ctrl;

   function automatic ucp_mode_t decode(input logic a, input logic b, input logic c, input logic dsc_var);
      ucp_mode_t m;
      m = M_OFF;
      if (dsc_var) begin
         if (!a && !b) m = M_AUTO;
         else if (!a) m = M_BC12;
         else if (!b) m = M_DIV;
         else if (!c) m = M_SDP;
         else m = M_CDP;
      end else begin
         if (!a && !b && !c) m = M_OFF;
         else if (!a && c) m = M_AUTO;
         else if (b && !c) m = M_SDP;
         else if (!b && !c) m = M_BC12;
         else if (!b) m = M_DIV;
         else m = M_CDP;
      end
      return m;
   endfunction : decode

   function automatic logic is_data(input ucp_mode_t m);
      return (m == M_SDP) || (m == M_CDP);
   endfunction : is_data

   always_comb begin
      st_d = st_q;
      dec = decode(mode_sel_a_i, mode_sel_b_i, mode_sel_c_i, HAS_DSC);
      qual = HAS_DSC ? discharge_request_in_i : enable_i;
      dsc_req = HAS_DSC && !discharge_request_in_i;
      // auto mode: divider first, bc1.2 held while the device stays attached
      auto_go = 1'b0;
      if (dec != M_AUTO) begin
         st_d.auto_bc12 = 1'b0;
      end else if (!st_q.auto_bc12 && bc12_attach_i) begin
         st_d.auto_bc12 = 1'b1;
         auto_go = 1'b1;
      end else if (!bc12_attach_i) begin
         st_d.auto_bc12 = 1'b0;
      end
      mode_chg = (dec != st_q.mode) && (is_data(dec) || is_data(st_q.mode));
      st_d.mode = dec;
      // register write lands in the data phase; the request is consumed next cycle
      wr_ctrl = st_q.a_sel && st_q.a_wr && (st_q.a_addr == CTRL_OFS) && hwdata_i[CTRL_DIS_BIT];
      start = mode_chg || auto_go || dsc_req || st_q.soft_dis || (dec == M_OFF);
      st_d.soft_dis = wr_ctrl;
      case (st_q.dis)
         D_IDLE: begin
            if (start) begin
               st_d.dis = D_DIS;
               st_d.cnt = DIS_LAST;
            end
         end
         D_DIS: begin
            if (start) begin
               st_d.cnt = DIS_LAST;                // held requests keep it draining
            end else if (st_q.cnt == '0) begin
               st_d.dis = D_IDLE;
            end else begin
               st_d.cnt = st_q.cnt - 1'b1;
            end
         end
         default: begin
            st_d.dis = D_IDLE;
         end
      endcase
      // first sensor trips only with current limit; stays off until it reports cooled
      if (temp_warn_i && current_limit_i) begin
         st_d.therm1 = 1'b1;
      end else if (!temp_warn_i) begin
         st_d.therm1 = 1'b0;
      end
      th_off = st_d.therm1 || temp_crit_i;
      // current limit alone keeps the switch on; the analog loop holds the current
      st_d.pwr = !uvlo_i && !th_off && (st_d.dis == D_IDLE) && (dec != M_OFF);
      st_d.dis_en = (st_d.dis == D_DIS);
      st_d.dsw = is_data(dec) && qual;
      st_d.lim_hi = limit_threshold_select_i;
      st_d.bc12 = (dec == M_BC12) || ((dec == M_AUTO) && st_d.auto_bc12);
      st_d.div = (dec == M_DIV) || ((dec == M_AUTO) && !st_d.auto_bc12);
      // deglitch: inrush into a big load must not flag a fault
      if (!current_limit_i) begin
         st_d.gcnt = '0;
         st_d.ilim_flt = 1'b0;
      end else if (st_q.gcnt >= DEG_LAST) begin
         st_d.ilim_flt = 1'b1;
      end else begin
         st_d.gcnt = st_q.gcnt + 1'b1;
      end
      st_d.flt = th_off || st_d.ilim_flt;
      st_d.flt_n = !st_d.flt;
      // ahb-lite slave, zero wait states
      st_d.hready = 1'b1;
      st_d.a_sel = hsel_i && htrans_i[1] && hready_i;
      st_d.a_wr = hwrite_i;
      st_d.a_addr = haddr_i[ADDR_W-1:0];
      if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
         if (haddr_i[ADDR_W-1:0] == STAT_OFS) begin
            st_d.hrdata = '0;
            st_d.hrdata[ST_MODE_LSB +: 6] = st_q.mode;
            st_d.hrdata[ST_AUTO_BIT] = st_q.auto_bc12;
            st_d.hrdata[ST_PWR_BIT] = st_q.pwr;
            st_d.hrdata[ST_DSW_BIT] = st_q.dsw;
            st_d.hrdata[ST_DIS_BIT] = st_q.dis_en;
            st_d.hrdata[ST_FLT_BIT] = st_q.flt;
            st_d.hrdata[ST_THERM_BIT] = st_q.therm1 || temp_crit_i;
         end else begin
            st_d.hrdata = '0;
         end
      end else begin
         st_d.hrdata = '0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign hrdata_o = st_q.hrdata;
   assign hreadyout_o = st_q.hready;
   assign hresp_o = 1'b0;
   assign data_switch_o = st_q.dsw;
   assign power_switch_o = st_q.pwr;
   assign discharge_o = st_q.dis_en;
   assign limit_set_high_o = st_q.lim_hi;
   assign dcp_bc12_o = st_q.bc12;
   assign dcp_divider_o = st_q.div;
   assign fault_n_o = st_q.flt_n;
   assign fault_oe_o = st_q.flt;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   property p_dsw_mode;
      data_switch_o |-> is_data(st_q.mode);
   endproperty
   a_dsw_mode: assert property (p_dsw_mode) else $error("data switch closed outside sdp or cdp");

   property p_dsw_open;
      (!is_data(st_q.mode)) |-> !data_switch_o;
   endproperty
   a_dsw_open: assert property (p_dsw_open) else $error("data switch closed in dedicated mode");

   property p_dsw_qual;
      (!qual && $stable(qual)) |=> !data_switch_o;
   endproperty
   a_dsw_qual: assert property (p_dsw_qual) else $error("data switch closed with qualifier low");

   property p_dsw_ilim;
      (data_switch_o && current_limit_i && is_data(dec) && qual) |=> data_switch_o;
   endproperty
   a_dsw_ilim: assert property (p_dsw_ilim) else $error("data switch opened by current limit");

   property p_off_mode;
      // the reset image holds the off code with the drain idle, so skip the edge right after release
      ((st_q.mode == M_OFF) && $past(nrst_i)) |-> (!power_switch_o && discharge_o && !data_switch_o);
   endproperty
   a_off_mode: assert property (p_off_mode) else $error("off code not honoured");

   property p_dis_pwr;
      discharge_o |-> !power_switch_o;
   endproperty
   a_dis_pwr: assert property (p_dis_pwr) else $error("power on while discharging");

   property p_chg_dis;
      ($changed(st_q.mode) && (is_data(st_q.mode) || is_data($past(st_q.mode)))) |-> discharge_o;
   endproperty
   a_chg_dis: assert property (p_chg_dis) else $error("no discharge on data mode change");

   property p_crit_off;
      temp_crit_i |=> (!power_switch_o && fault_oe_o && !fault_n_o);
   endproperty
   a_crit_off: assert property (p_crit_off) else $error("critical temperature not acted on");

   property p_warn_off;
      (temp_warn_i && current_limit_i) |=> (!power_switch_o && fault_oe_o);
   endproperty
   a_warn_off: assert property (p_warn_off) else $error("warn with limit did not shut off");

   property p_deglitch;
      (current_limit_i && !$past(current_limit_i) && !temp_warn_i && !temp_crit_i) |-> !st_d.ilim_flt;
   endproperty
   a_deglitch: assert property (p_deglitch) else $error("current limit flagged without deglitch");

   property p_uvlo;
      uvlo_i |=> !power_switch_o;
   endproperty
   a_uvlo: assert property (p_uvlo) else $error("power on during undervoltage");

   property p_limsel;
      limit_threshold_select_i |=> limit_set_high_o;
   endproperty
   a_limsel: assert property (p_limsel) else $error("limit select not followed");

   c_dis_done: cover property ($fell(discharge_o) ##1 power_switch_o);
   c_auto_bc12: cover property ((dec == M_AUTO) && auto_go);
   c_fault: cover property ($rose(fault_oe_o) && !temp_crit_i && !temp_warn_i);
   c_cdp_on: cover property ((st_q.mode == M_CDP) && data_switch_o && power_switch_o);
endmodule : ucp_top

/* dv/ucp_port_model.sv */
// Purpose: behavioural model of the attached device and the analog sense side of the port
// Assumes: commands from the bench are levels sampled on the system clock
// Notes: sensors carry their own hysteresis, so the model only reports levels
`timescale 1ns/1ps
module ucp_port_model (
   input wire logic clk_sys_i,     // system clock
   input wire logic overload_i,    // bench asks for a load beyond the limit
   input wire logic [1:0] heat_i,  // 0 cool, 1 above first level, 2 above both
   input wire logic attach_i,      // bench asks for a bc1.2 device to attach
   input wire logic brown_i,       // bench asks for a sagging supply
   output logic current_limit_o,   // switch regulating current
   output logic temp_warn_o,       // first sensor tripped
   output logic temp_crit_o,       // second sensor tripped
   output logic uvlo_o,            // supply below turn-on level
   output logic bc12_attach_o      // bc1.2 device present
);
   // registered so that every level change lands one edge after the command
   always_ff @(posedge clk_sys_i) begin
      current_limit_o <= overload_i;
      temp_warn_o <= (heat_i != 2'h0);
      temp_crit_o <= (heat_i == 2'h2);
      uvlo_o <= brown_i;
      bc12_attach_o <= attach_i;
   end
endmodule : ucp_port_model

/* dv/test_ucp_top.sv */
// Purpose: self-checking bench for the charging port mode controller
// Assumes: variant without discharge pin, short discharge and deglitch counts
// Notes: a queue of expected values is drained by a separate monitor process
`timescale 1ns/1ps
module test_ucp_top;
   import ucp_pkg::*;
   localparam int DIS = 4;
   localparam int DEG = 3;
   logic clk_sys_i = 1'b0, nrst_i = 1'b0, a = 1'b0, b = 1'b0, c = 1'b0, en = 1'b1, lts = 1'b0;
   logic ovl = 1'b0, att = 1'b0, brn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] heat = 2'h0, htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, rd_seen;
   logic hready, hresp, ds, pw, dis, lsh, bc, dv, fn, foe, cl, tw, tc, uv, ba;
   logic [6:0] exp_pin;
   logic [31:0] exp_word;
   logic [31:0] seed = 32'hfa2e;
   int err_total = 0, n_checks = 0, cyc = 0;
   logic [6:0] exp_pins[$];
   logic [31:0] exp_rd[$];
   event pin_evt, rd_evt;
   always #20 clk_sys_i = ~clk_sys_i;
   ucp_port_model u_env (.clk_sys_i(clk_sys_i), .overload_i(ovl), .heat_i(heat), .attach_i(att),
      .brown_i(brn), .current_limit_o(cl), .temp_warn_o(tw), .temp_crit_o(tc), .uvlo_o(uv),
      .bc12_attach_o(ba));
   ucp_top #(.HAS_DSC(1'b0), .DIS_CYC(DIS), .DEG_CYC(DEG)) u_dut (.clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i), .mode_sel_a_i(a), .mode_sel_b_i(b), .mode_sel_c_i(c), .enable_i(en),
      .discharge_request_in_i(1'b1), .limit_threshold_select_i(lts), .current_limit_i(cl),
      .temp_warn_i(tw), .temp_crit_i(tc), .uvlo_i(uv), .bc12_attach_i(ba), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .data_switch_o(ds), .power_switch_o(pw), .discharge_o(dis), .limit_set_high_o(lsh),
      .dcp_bc12_o(bc), .dcp_divider_o(dv), .fault_n_o(fn), .fault_oe_o(foe));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   task automatic cmp_pins(input logic [6:0] e, input logic [6:0] s);
      n_checks++;
      if (s !== e) begin
         err_total++;
         $display("unexpected pins {ds,pw,dis,bc,dv,fault_n,lsh} exp %b seen %b", e, s);
      end
   endtask : cmp_pins
   task automatic cmp_word(input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         err_total++;
         $display("unexpected hrdata exp %h seen %h", e, s);
      end
   endtask : cmp_word
   task automatic cmp_bit(input string nm, input logic e, input logic s);
      n_checks++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s exp %b seen %b", nm, e, s);
      end
   endtask : cmp_bit
   always @(pin_evt) begin
      exp_pin = exp_pins.pop_front();
      cmp_pins(exp_pin, {ds, pw, dis, bc, dv, fn, lsh});
      cmp_bit("fault_oe", ~exp_pin[1], foe);
      cmp_bit("hresp", 1'b0, hresp);
   end
   always @(rd_evt) begin
      exp_word = exp_rd.pop_front();
      cmp_word(exp_word, rd_seen);
   end
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc > 6000) begin
         err_total++;
         stop_test();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : step
   // expectation {ds,pw,dis,bc,dv,fault_n}; the threshold select is appended here
   task automatic chk(input logic [5:0] e);
      #1;
      exp_pins.push_back({e, lts});
      -> pin_evt;
   endtask : chk
   task automatic ahb(input logic wr, input logic [31:0] ad, input logic [31:0] wd, input logic [31:0] e);
      @(posedge clk_sys_i);
      hsel <= 1'b1;
      haddr <= ad;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge clk_sys_i); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clk_sys_i); while (hready !== 1'b1);
      rd = hrdata;
      if (!wr) begin
         exp_rd.push_back(e);
         rd_seen = rd;
         -> rd_evt;
      end
   endtask : ahb
   function automatic logic [5:0] exp_dec(input logic [2:0] k, input logic q);
      casez (k)
         3'b000: exp_dec = 6'b001001;
         3'b0?1: exp_dec = 6'b010011;
         3'b?10: exp_dec = {q, 5'b10001};
         3'b100: exp_dec = 6'b010101;
         3'b101: exp_dec = 6'b010011;
         default: exp_dec = {q, 5'b10001};
      endcase
   endfunction : exp_dec
   initial begin
      step(4);
      nrst_i <= 1'b1;
      chk(6'b000001);
      for (int q = 1; q >= 0; q--) begin
         for (int k = 0; k < 8; k++) begin
            step(1);
            {a, b, c} <= 3'(k);
            en <= q[0];
            lts <= $random(seed);
            step(DIS + 8);
            chk(exp_dec(3'(k), q[0]));
         end
      end
      step(1);
      en <= 1'b1;
      {a, b, c} <= 3'b010;
      step(DIS + 8);
      {a, b, c} <= 3'b111;
      step(1);
      chk(6'b101001);
      // drain stands for DIS cycles: reload to DIS-1, count down, leave on zero
      step(DIS - 1);
      chk(6'b101001);
      step(1);
      chk(6'b110001);
      ovl <= 1'b1;
      // model adds one edge; the flag rises on the DEG-th high sample
      step(DEG);
      chk(6'b110001);
      step(1);
      chk(6'b110000);
      heat <= 2'h1;
      step(2);
      chk(6'b100000);
      heat <= 2'h0;
      step(2);
      chk(6'b110000);
      ovl <= 1'b0;
      step(2);
      chk(6'b110001);
      heat <= 2'h2;
      step(2);
      chk(6'b100000);
      heat <= 2'h0;
      step(4);
      chk(6'b110001);
      brn <= 1'b1;
      step(2);
      chk(6'b100001);
      brn <= 1'b0;
      step(4);
      chk(6'b110001);
      {a, b, c} <= 3'b001;
      step(DIS + 8);
      att <= 1'b1;
      step(2);
      chk(6'b001101);
      step(DIS + 8);
      chk(6'b010101);
      att <= 1'b0;
      step(2);
      chk(6'b010011);
      ahb(1'b1, 32'(CTRL_OFS), ($random(seed) & 32'hfffffff0) | 32'h1, 32'h0);
      step(1);
      chk(6'b001011);
      step(DIS + 8);
      ahb(1'b0, 32'(STAT_OFS), 32'h0, 32'h0000_0082);
      ahb(1'b0, 32'(CTRL_OFS), 32'h0, 32'h0);
      ahb(1'b0, 32'h0000_0010, 32'h0, 32'h0);
      step(2);
      stop_test();
   end
endmodule : test_ucp_top
